// [bench/iogdp_cpu_model.sv]
`default_nettype none
module iogdp_cpu_model
  import iogdp_pkg::*;
(
  input wire logic clock_in,
  input wire logic [WORD_W-1:0] bus_data_out,
  output iogdp_bus_req_s bus_req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_req_out = '0;
  // One-cycle instruction; released kind lines go to zero, code and data lines show inverted values, not the old ones
  task automatic instr(input logic [3:0] kind, input logic [6:0] code,
    input logic [35:0] data, output logic [35:0] rd);
    @(posedge clock_in);
    bus_req_out <= {kind, code, data};
    @(posedge clock_in);
    bus_req_out <= {4'h0, ~code, ~data};
    // The answer stands for one cycle after the take edge only
    #1 rd = bus_data_out;
  endtask
endmodule
`default_nettype wire

// [bench/iogdp_props.sv]
`default_nettype none
module iogdp_props
  import iogdp_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Bus side
  input wire iogdp_bus_req_s bus_req_in,
  input wire logic bus_reset_pulse_in,
  input wire logic [WORD_W-1:0] bus_data_out,
  input wire logic bus_data_valid_out,
  input wire logic [UNIT_W-1:0] unit_select_bit_true_in,
  input wire logic [UNIT_W-1:0] unit_select_bit_comp_in,
  // User side
  input wire logic [LEVEL_N-1:0] status_level_in,
  input wire logic [WORD_W-1:0] user_word_in,
  input wire logic [CSW_W-1:0] control_word_out,
  input wire logic [FLAG_N-1:0] control_flags_out,
  input wire iogdp_pulses_s user_pulses_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic hit;
  logic rd_any;
  // Taken only with a legal strap and no bus reset overriding it
  assign hit = (&(unit_select_bit_true_in ^ unit_select_bit_comp_in)) && !bus_reset_pulse_in
    && bus_req_in.unit_select_code == unit_select_bit_true_in;
  assign rd_any = hit && (bus_req_in.word_input_instr || bus_req_in.control_read_instr);
  // Load strobes follow their clear strobes by the fixed spacing
  sequence word_load_later;
    ##250 $rose(user_pulses_out.word_load_pulse);
  endsequence
  sequence ctrl_load_later;
    ##250 $rose(user_pulses_out.control_load_pulse);
  endsequence
  chk_read_answer: assert property (rd_any |=> bus_data_valid_out)
    else $error("read not answered");
  chk_no_answer: assert property (!rd_any |=> !bus_data_valid_out)
    else $error("answer without selected read");
  chk_input_word: assert property (hit && bus_req_in.word_input_instr
    |=> bus_data_out == $past(user_word_in)) else $error("input word wrong");
  chk_level_bits: assert property (hit && bus_req_in.control_read_instr
    |=> bus_data_out[17:15] == $past(status_level_in) && bus_data_out[35:18] == 18'h00000)
    else $error("status levels wrong");
  chk_word_pulse: assert property ($rose(user_pulses_out.word_clear_pulse)
    |-> ##24 user_pulses_out.word_clear_pulse ##1 !user_pulses_out.word_clear_pulse)
    else $error("word clear width wrong");
  chk_word_space: assert property ($rose(user_pulses_out.word_clear_pulse)
    |-> word_load_later)
    else $error("word load spacing wrong");
  chk_ctrl_space: assert property ($rose(user_pulses_out.control_clear_pulse)
    && !user_pulses_out.general_reset_pulse |-> ctrl_load_later)
    else $error("control load spacing wrong");
  // The control word output is registered one cycle behind the clear strobe
  chk_ctrl_word: assert property ($rose(user_pulses_out.control_clear_pulse)
    && !user_pulses_out.general_reset_pulse
    |-> ##1 control_word_out == $past(bus_req_in.data[17:0], 2))
    else $error("control word wrong");
  chk_bus_reset: assert property (bus_reset_pulse_in
    |=> user_pulses_out.general_reset_pulse
    && user_pulses_out.control_clear_pulse ##1 control_flags_out == 6'h00)
    else $error("bus reset effect wrong");
  // A retrigger only stretches the strobe, so back to back inputs still hold
  chk_input_done: assert property (hit && bus_req_in.word_input_instr
    |=> user_pulses_out.input_complete_pulse ##24 user_pulses_out.input_complete_pulse)
    else $error("input complete pulse wrong");
endmodule
`default_nettype wire

// [bench/test_iogdp_top.sv]
`default_nettype none
module test_iogdp_top;
  timeunit 1ns;
  timeprecision 1ps;
  import iogdp_pkg::*;
  logic clock_in, rst_in, bus_reset_pulse_in, bus_data_valid_out;
  iogdp_bus_req_s bus_req;
  logic [35:0] bus_data_out, user_word_in, user_word_out, rd;
  logic [6:0] interrupt_request_out;
  logic [5:0] set_status_in, control_flags_out;
  logic [2:0] status_level_in;
  logic [17:0] control_word_out;
  logic [6:0] strap_comp;
  logic [5:0] irq_en;
  iogdp_pulses_s user_pulses_out;
  int n_mismatch = 0;
  int num_checks = 0;
  localparam logic [6:0] UNIT = 7'h45;
  localparam logic [35:0] CW1 = {18'h00000, 3'h5, 6'h2D, 6'h00, 3'h2};
  localparam logic [35:0] CW2 = {18'h00000, 3'h0, 6'h2D, 6'h3F, 3'h0};
  iogdp_cpu_model cpu (.clock_in(clock_in), .bus_data_out(bus_data_out), .bus_req_out(bus_req));
  // Flag 1 unconnected, then neither, input, output, either, neither
  iogdp_top dut (.clock_in(clock_in), .rst_in(rst_in), .bus_req_in(bus_req),
    .bus_reset_pulse_in(bus_reset_pulse_in), .bus_data_out(bus_data_out),
    .bus_data_valid_out(bus_data_valid_out), .interrupt_request_out(interrupt_request_out),
    .unit_select_bit_true_in(UNIT), .unit_select_bit_comp_in(strap_comp),
    .status_clear_sel_in({3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1}), .status_irq_enable_in(irq_en),
    .user_word_in(user_word_in), .set_status_in(set_status_in),
    .status_level_in(status_level_in), .user_word_out(user_word_out),
    .control_word_out(control_word_out), .control_flags_out(control_flags_out),
    .user_pulses_out(user_pulses_out));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_control;
    cpu.instr(4'h2, UNIT, CW1, rd);
    wait_cyc(280);
    chk(control_flags_out, 6'h2D);
    chk(control_word_out, CW1[17:0]);
    cpu.instr(4'h1, UNIT, 36'h0, rd);
    chk(rd, {18'h00000, 3'h6, 6'h2D, 6'h00, 3'h2});
  endtask
  task automatic t_flags;
    // Set strobe held for 100 ns
    set_status_in <= 6'h3F;
    wait_cyc(25);
    set_status_in <= 6'h00;
    wait_cyc(3);
    chk(interrupt_request_out, 7'h02);
    // No flag enabled as a source: the request must drop
    irq_en <= 6'h00;
    wait_cyc(2);
    chk(interrupt_request_out, 7'h00);
    irq_en <= 6'h3F;
    cpu.instr(4'h1, UNIT, 36'h0, rd);
    chk(rd[8:3], 6'h1F);
    cpu.instr(4'h4, UNIT, 36'h0, rd);
    chk(rd, user_word_in);
    cpu.instr(4'h1, UNIT, 36'h0, rd);
    chk(rd[8:3], 6'h15);
    cpu.instr(4'h8, UNIT, 36'hF_0F0F_0F0F, rd);
    chk(user_word_out, 36'hF_0F0F_0F0F);
    cpu.instr(4'h1, UNIT, 36'h0, rd);
    chk(rd[8:3], 6'h11);
    wait_cyc(280);
    cpu.instr(4'h2, UNIT, CW2, rd);
    wait_cyc(280);
    cpu.instr(4'h1, UNIT, 36'h0, rd);
    chk(rd[8:3], 6'h00);
    set_status_in <= 6'h01;
    wait_cyc(25);
    set_status_in <= 6'h00;
    wait_cyc(3);
    chk(interrupt_request_out, 7'h00);
  endtask
  task automatic t_other;
    cpu.instr(4'h1, UNIT ^ 7'h40, 36'h0, rd);
    chk(rd, 36'h0);
    // Both options fitted on bit 0: the port must stay silent
    strap_comp <= ~UNIT | 7'h01;
    cpu.instr(4'h1, UNIT, 36'h0, rd);
    chk(rd, 36'h0);
    strap_comp <= ~UNIT;
  endtask
  task automatic t_reset;
    bus_reset_pulse_in <= 1'b1;
    @(posedge clock_in);
    bus_reset_pulse_in <= 1'b0;
    wait_cyc(3);
    chk(control_flags_out, 6'h00);
    cpu.instr(4'h1, UNIT, 36'h0, rd);
    chk(rd[14:0], 15'h0000);
  endtask
  // Free-running clock
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // Run is about 930 cycles, so 50 us means a hang
  initial begin
    #50000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    rst_in = 1'b1;
    bus_reset_pulse_in = 1'b0;
    set_status_in = 6'h00;
    status_level_in = 3'h6;
    strap_comp = ~UNIT;
    irq_en = 6'h3F;
    // Narrow user data sits right-justified
    user_word_in = 36'h0_0000_4321;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    wait_cyc(2);
    t_control();
    t_flags();
    t_other();
    t_reset();
    stop_test();
  end
endmodule
bind iogdp_top iogdp_props props_i (.clock_in(clock_in), .rst_in(rst_in),
  .bus_req_in(bus_req_in), .bus_reset_pulse_in(bus_reset_pulse_in),
  .bus_data_out(bus_data_out), .bus_data_valid_out(bus_data_valid_out),
  .unit_select_bit_true_in(unit_select_bit_true_in),
  .unit_select_bit_comp_in(unit_select_bit_comp_in),
  .status_level_in(status_level_in), .user_word_in(user_word_in),
  .control_word_out(control_word_out), .control_flags_out(control_flags_out),
  .user_pulses_out(user_pulses_out));
`default_nettype wire

// [hw/iogdp_pkg.sv]
`default_nettype none
package iogdp_pkg;
  // Bus geometry
  localparam int WORD_W = 36;
  localparam int CSW_W = 18;
  localparam int UNIT_W = 7;
  localparam int FLAG_N = 6;
  localparam int CHAN_W = 3;
  localparam int LEVEL_N = 3;

  // Status word layout, index = 35 - bit number
  localparam int CSW_CHAN_LSB = 0;
  localparam int CSW_STAT_LSB = 3;
  localparam int CSW_CTRL_LSB = 9;
  localparam int CSW_LVL_LSB = 15;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
  localparam logic [FLAG_N-1:0] FLAG_RESET = 6'h00;
  localparam logic [CHAN_W-1:0] CHAN_OFF = 3'h0;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PULSE_NS = 100;
  localparam int SPACING_NS = 1000;
  localparam int PULSE_CYC = (PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SPACING_CYC = (SPACING_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 9;

  // Per-flag clear source selection
  typedef enum logic [2:0] {
    CLRSEL_UNCONNECTED = 3'h0,
    CLRSEL_NEITHER = 3'h1,
    CLRSEL_INPUT = 3'h2,
    CLRSEL_OUTPUT = 3'h3,
    CLRSEL_EITHER = 3'h4
  } iogdp_clrsel_e;

  // Two-pulse sequencer, Gray along IDLE-CLEAR-GAP-LOAD
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_CLEAR = 2'h1,
    SEQ_GAP = 2'h3,
    SEQ_LOAD = 2'h2
  } iogdp_seq_e;

  // One bus instruction as seen on the buffered bus
  typedef struct packed {
    logic word_output_instr;
    logic word_input_instr;
    logic control_write_instr;
    logic control_read_instr;
    logic [UNIT_W-1:0] unit_select_code;
    logic [WORD_W-1:0] data;
  } iogdp_bus_req_s;

  // Strobes handed to the user logic
  typedef struct packed {
    logic word_clear_pulse;
    logic word_load_pulse;
    logic control_clear_pulse;
    logic control_load_pulse;
    logic input_complete_pulse;
    logic general_reset_pulse;
  } iogdp_pulses_s;
endpackage
`default_nettype wire

// [hw/iogdp_top.sv]
// Behaviour
// - Answer one configured unit number of 128; ignore instructions for others.
// - Each select bit needs exactly one of true/complement fitted to match.
// - Word output passes the full 36-bit bus word to user logic.
// - Word input returns the 36-bit user word to the processor.
// - Word output may clear selected status flags 27..32.
// - Each flag clears on input, output, either, or neither, plus control write.
// - A flag with unconnected clear selection stays cleared.
// - User logic sets flags; they hold until a configured clear.
// - Control read returns channel, status, control flags and three levels.
// - Request interrupt on programmed channel while an enabled flag is set.
// - Control write takes the effective address itself as data.
// - Control write loads bits 33..35 into the interrupt channel.
// - Control write ones in bits 27..32 clear matching flags.
// - Control write loads bits 21..26 into control flags shown to user.
// - Control write bits 18..35 are offered to user logic.
// - Control, status and channel clear on power-on and bus reset.
// - Bus signals are buffered so user faults cannot disturb the bus.
// - Control write runs clear pulse then load pulse 1 us apart, both exported.
// - Each word input is followed by a 100 ns completion pulse.
// - Word output gives clear then load pulse 1 us apart.
`default_nettype none
module iogdp_top
  import iogdp_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Processor bus side
  input wire iogdp_pkg::iogdp_bus_req_s bus_req_in,
  input wire logic bus_reset_pulse_in,
  output logic [iogdp_pkg::WORD_W-1:0] bus_data_out,
  output logic bus_data_valid_out,
  output logic [6:0] interrupt_request_out,
  // Configuration straps
  input wire logic [iogdp_pkg::UNIT_W-1:0] unit_select_bit_true_in,
  input wire logic [iogdp_pkg::UNIT_W-1:0] unit_select_bit_comp_in,
  input wire logic [iogdp_pkg::FLAG_N-1:0][2:0] status_clear_sel_in,
  input wire logic [iogdp_pkg::FLAG_N-1:0] status_irq_enable_in,
  // User logic side
  input wire logic [iogdp_pkg::WORD_W-1:0] user_word_in,
  input wire logic [iogdp_pkg::FLAG_N-1:0] set_status_in,
  input wire logic [iogdp_pkg::LEVEL_N-1:0] status_level_in,
  output logic [iogdp_pkg::WORD_W-1:0] user_word_out,
  output logic [iogdp_pkg::CSW_W-1:0] control_word_out,
  output logic [iogdp_pkg::FLAG_N-1:0] control_flags_out,
  output iogdp_pkg::iogdp_pulses_s user_pulses_out
);
  import iogdp_pkg::*;

  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] SPACE_LAST = CNT_W'(SPACING_CYC - 1);

  iogdp_seq_e seq_q, seq_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] ic_cnt_q, rst_cnt_q;
  logic is_ctl_q;
  logic [CHAN_W-1:0] chan_q;
  logic [FLAG_N-1:0] status_q, status_d;
  logic [FLAG_N-1:0] ctrl_q;
  logic [CSW_W-1:0] cw_word_q;
  logic select_ok, hit, take_seq, take_wi, enter_clear, enter_load;
  logic [FLAG_N-1:0] clr_in_m, clr_out_m, unconn_m;
  logic [CSW_W-1:0] csw;

  // Decoder: a bit with both or neither option fitted never matches
  // A strap fault leaves the port silent rather than answering on several numbers
  always_comb begin
    select_ok = 1'b1;
    for (int i = 0; i < UNIT_W; i++) begin
      if (unit_select_bit_true_in[i] == unit_select_bit_comp_in[i]) begin
        select_ok = 1'b0;
      end else if (unit_select_bit_true_in[i] != bus_req_in.unit_select_code[i]) begin
        select_ok = 1'b0;
      end
    end
  end

  assign hit = select_ok && !bus_reset_pulse_in;
  // Two-pulse instructions arriving mid-sequence are dropped; the bus never waits on us
  assign take_seq = hit && (seq_q == SEQ_IDLE)
                    && (bus_req_in.word_output_instr || bus_req_in.control_write_instr);
  assign take_wi = hit && bus_req_in.word_input_instr;

  // Per-flag clear sources decoded from the straps
  // Unused strap codes fall through as neither, so a bad strap cannot erase flags
  always_comb begin
    for (int i = 0; i < FLAG_N; i++) begin
      unconn_m[i] = (status_clear_sel_in[i] == 3'(CLRSEL_UNCONNECTED));
      clr_in_m[i] = (status_clear_sel_in[i] == 3'(CLRSEL_INPUT))
                    || (status_clear_sel_in[i] == 3'(CLRSEL_EITHER));
      clr_out_m[i] = (status_clear_sel_in[i] == 3'(CLRSEL_OUTPUT))
                     || (status_clear_sel_in[i] == 3'(CLRSEL_EITHER));
    end
  end

  // Sequencer next state: clear pulse, gap to 1 us, load pulse
  always_comb begin
    seq_d = seq_q;
    cnt_d = cnt_q + CNT_W'(1);
    case (seq_q)
      SEQ_IDLE: begin
        cnt_d = '0;
        if (take_seq) begin
          seq_d = SEQ_CLEAR;
        end
      end
      SEQ_CLEAR: begin
        if (cnt_q == PULSE_LAST) begin
          seq_d = SEQ_GAP;
        end
      end
      SEQ_GAP: begin
        if (cnt_q == SPACE_LAST) begin
          seq_d = SEQ_LOAD;
          cnt_d = '0;
        end
      end
      SEQ_LOAD: begin
        if (cnt_q == PULSE_LAST) begin
          seq_d = SEQ_IDLE;
          cnt_d = '0;
        end
      end
      default: begin
        seq_d = SEQ_IDLE;
        cnt_d = '0;
      end
    endcase
    if (bus_reset_pulse_in) begin
      seq_d = SEQ_IDLE;
      cnt_d = '0;
    end
  end

  assign enter_clear = take_seq;
  assign enter_load = (seq_q == SEQ_GAP) && (seq_d == SEQ_LOAD);

  // Sequencer registers
  // is_ctl_q remembers which pulse pair is running, so the load phase knows its target
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      seq_q <= SEQ_IDLE;
      cnt_q <= '0;
      is_ctl_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
      if (take_seq) begin
        is_ctl_q <= bus_req_in.control_write_instr;
      end
    end
  end

  // Words to the user are latched at take, on the edge that raises the clear pulse, so they are stable before the load pulse
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      user_word_out <= '0;
      cw_word_q <= '0;
    end else if (take_seq) begin
      if (bus_req_in.control_write_instr) begin
        cw_word_q <= bus_req_in.data[CSW_W-1:0];
      end else begin
        user_word_out <= bus_req_in.data;
      end
    end
  end

  // Channel and control flags: cleared by the clear phase, loaded by the load phase
  // Bus reset outranks any instruction that lands in the same cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      chan_q <= CHAN_RESET;
      ctrl_q <= FLAG_RESET;
    end else if (bus_reset_pulse_in) begin
      chan_q <= CHAN_RESET;
      ctrl_q <= FLAG_RESET;
    end else if (enter_clear && bus_req_in.control_write_instr) begin
      chan_q <= CHAN_RESET;
      ctrl_q <= FLAG_RESET;
    end else if (enter_load && is_ctl_q) begin
      chan_q <= cw_word_q[CSW_CHAN_LSB +: CHAN_W];
      ctrl_q <= cw_word_q[CSW_CTRL_LSB +: FLAG_N];
    end
  end

  // Status flags; a set beats an instruction clear in the same cycle, but unconnected selection and bus reset beat a set
  always_comb begin
    for (int i = 0; i < FLAG_N; i++) begin
      status_d[i] = status_q[i];
      if ((enter_load && is_ctl_q && cw_word_q[CSW_STAT_LSB + i])
          || (take_wi && clr_in_m[i])
          || (enter_clear && bus_req_in.word_output_instr && clr_out_m[i])) begin
        status_d[i] = 1'b0;
      end
      if (set_status_in[i]) begin
        status_d[i] = 1'b1;
      end
      if (unconn_m[i] || bus_reset_pulse_in) begin
        status_d[i] = 1'b0;
      end
    end
  end

  // Status register; overrides are already folded into status_d
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      status_q <= FLAG_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Status word as read back
  assign csw = {status_level_in, ctrl_q, status_q, chan_q};

  // Bus answer: registered so nothing from the user side reaches the bus directly
  // An idle bus sees zeros, never stale user data
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bus_data_out <= '0;
      bus_data_valid_out <= 1'b0;
    end else begin
      bus_data_valid_out <= 1'b0;
      bus_data_out <= '0;
      if (take_wi) begin
        bus_data_out <= user_word_in;
        bus_data_valid_out <= 1'b1;
      end else if (hit && bus_req_in.control_read_instr) begin
        bus_data_out <= {{(WORD_W - CSW_W){1'b0}}, csw};
        bus_data_valid_out <= 1'b1;
      end
    end
  end

  // Interrupt request: one line per channel 1..7, none for channel zero
  // Channel zero is filtered first, so the index below never wraps
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      interrupt_request_out <= 7'h00;
    end else begin
      interrupt_request_out <= 7'h00;
      if ((|(status_q & status_irq_enable_in)) && (chan_q != CHAN_OFF)) begin
        interrupt_request_out[chan_q - 3'h1] <= 1'b1;
      end
    end
  end

  // Completion and reset pulse timers
  // A new event reloads the full width, so a retrigger only stretches the strobe
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ic_cnt_q <= '0;
      rst_cnt_q <= '0;
    end else begin
      if (take_wi) begin
        ic_cnt_q <= CNT_W'(PULSE_CYC);
      end else if (ic_cnt_q != '0) begin
        ic_cnt_q <= ic_cnt_q - CNT_W'(1);
      end
      if (bus_reset_pulse_in) begin
        rst_cnt_q <= CNT_W'(PULSE_CYC);
      end else if (rst_cnt_q != '0) begin
        rst_cnt_q <= rst_cnt_q - CNT_W'(1);
      end
    end
  end

  // User strobes, registered; reset also fires the control clear strobe
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      user_pulses_out <= '0;
      control_flags_out <= FLAG_RESET;
      control_word_out <= '0;
    end else begin
      user_pulses_out.word_clear_pulse <= (seq_d == SEQ_CLEAR) && !is_ctl_d();
      user_pulses_out.word_load_pulse <= (seq_d == SEQ_LOAD) && !is_ctl_d();
      user_pulses_out.control_clear_pulse <= ((seq_d == SEQ_CLEAR) && is_ctl_d())
                                             || (seq_d == SEQ_IDLE && rst_cnt_d_nz());
      user_pulses_out.control_load_pulse <= (seq_d == SEQ_LOAD) && is_ctl_d();
      user_pulses_out.input_complete_pulse <= take_wi || (ic_cnt_q > CNT_W'(1));
      user_pulses_out.general_reset_pulse <= rst_cnt_d_nz();
      control_flags_out <= ctrl_q;
      control_word_out <= cw_word_q;
    end
  end

  // Helpers look one cycle ahead so the registered strobes line up with the sequencer
  // Kind of the sequence that will be running next cycle
  function automatic logic is_ctl_d();
    is_ctl_d = take_seq ? bus_req_in.control_write_instr : is_ctl_q;
  endfunction

  // Reset strobe stays high for one pulse width from the bus reset
  function automatic logic rst_cnt_d_nz();
    rst_cnt_d_nz = bus_reset_pulse_in || (rst_cnt_q > CNT_W'(1));
  endfunction
endmodule
`default_nettype wire
